// file: hw/bflg_flags.sv
// bus-busy, receive-overrun and transmit-underflow flags with registers
//
// Behaviour
// - stop on bus clears busy flag
// - start on bus sets busy flag
// - module reset clears busy, overrun; sets nonempty
// - byte arrives while holding unread sets overrun
// - overrun keeps shifting, withholds copy until read
// - processor read clears overrun, debug read not
// - empty shift, unwritten holding clears nonempty
// - underflow delays copy, old byte resent
// - holding write sets nonempty flag
// - busy flag sits at status bit 12
// - copy sets ready flag, write clears it
`timescale 1ns/10ps
`default_nettype none

module bflg_flags
  import bflg_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [REG_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic dbg_rd_in,
  output logic [REG_W-1:0] rd_data_out,
  // two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // own sequencer conditions
  input wire logic tx_start_evt_in,
  input wire logic tx_stop_evt_in,
  // status
  output logic busy_out,
  output logic irq_out
);

  // ==========================================================
  // pin synchronisation and condition detection
  logic scl_q;
  logic sda_q;
  bflg_cond_t cond;

  bflg_sync #(.W(2)) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in({scl_in, sda_in}),
    .q_out({scl_q, sda_q})
  );

  bflg_cond u_cond (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .scl_in(scl_q),
    .sda_in(sda_q),
    .cond_out(cond)
  );

  // ==========================================================
  // qualified strobes and events
  bflg_state_t s;
  bflg_state_t next_s;
  logic run;
  logic start_ev;
  logic stop_ev;
  logic cpu_rd_hold;
  logic dbg_rd_hold;
  logic hold_wr;
  logic stat_wr;
  logic byte_done;
  logic tx_fall;
  logic bnd;
  logic [INT_W-1:0] int_clr;

  assign run = s.ctl[CTL_RUN];
  assign start_ev = cond.start | tx_start_evt_in;
  assign stop_ev = cond.stop | tx_stop_evt_in;
  // an emulator read is flagged beside the strobe and has no side effect
  assign cpu_rd_hold = run & rd_in & ~dbg_rd_in & (addr_in == OFS_RX_HOLD);
  assign dbg_rd_hold = run & rd_in & dbg_rd_in & (addr_in == OFS_RX_HOLD);
  assign hold_wr = run & wr_in & (addr_in == OFS_TX_HOLD);
  assign stat_wr = wr_in & (addr_in == OFS_STATUS);
  assign byte_done = run & s.ctl[CTL_RX_EN] & s.busy & cond.scl_rise
    & (s.rx_cnt == LAST_BIT);
  assign tx_fall = run & s.ctl[CTL_TX_EN] & s.busy & cond.scl_fall;
  assign bnd = tx_fall & (s.tx_cnt == 3'h0);
  assign int_clr = (wr_in && addr_in == OFS_INT_ST)
    ? wr_data_in[INT_W-1:0] : '0;

  // ==========================================================
  // next-state logic
  always_comb
  begin
    logic [INT_W-1:0] ev;
    logic [BYTE_W-1:0] tx_byte;
    logic [BYTE_W-1:0] rx_new;
    ev = '0;
    tx_byte = s.tx_sh;
    rx_new = {s.rx_sh[BYTE_W-2:0], sda_q};
    next_s = s;
    next_s.rd_data = '0;

    // software-writable control; status writes fall through untouched
    if (wr_in)
    begin
      case (addr_in)
        OFS_CTRL: next_s.ctl = wr_data_in[CTL_W-1:0];
        OFS_INT_MASK: next_s.int_mask = wr_data_in[INT_W-1:0];
        default: ;
      endcase
    end

    if (!run)
    begin
      // module reset holds the flags at their idle values
      next_s.busy = 1'b0;
      next_s.overrun = 1'b0;
      next_s.nonempty = 1'b1;
      next_s.tx_ready = 1'b1;
      next_s.rx_unread = 1'b0;
      next_s.tx_hold_full = 1'b0;
      next_s.rx_cnt = 3'h0;
      next_s.tx_cnt = 3'h0;
      next_s.sda_oe = 1'b0;
    end
    else
    begin
      // start wins over stop: a coincident pair means a new frame
      if (start_ev)
      begin
        next_s.busy = 1'b1;
        next_s.rx_cnt = 3'h0;
        next_s.tx_cnt = 3'h0;
        ev[INT_START] = 1'b1;
      end
      else if (stop_ev)
      begin
        next_s.busy = 1'b0;
        ev[INT_STOP] = 1'b1;
      end

      // a processor read frees the holding register and takes the
      // byte that waited in the shift register
      if (cpu_rd_hold)
      begin
        next_s.overrun = 1'b0;
        next_s.rx_unread = 1'b0;
        if (s.overrun)
        begin
          next_s.rx_hold = s.rx_sh;
          next_s.rx_unread = 1'b1;
        end
      end

      // receive: sample on rising clock, bits keep overwriting
      if (s.ctl[CTL_RX_EN] && s.busy && cond.scl_rise && !start_ev)
      begin
        next_s.rx_sh = rx_new;
        next_s.rx_cnt = s.rx_cnt + 3'h1;
        if (s.rx_cnt == LAST_BIT)
        begin
          ev[INT_RXB] = 1'b1;
          if (next_s.rx_unread)
          begin
            next_s.overrun = 1'b1;
            ev[INT_OVR] = 1'b1;
          end
          else
          begin
            next_s.rx_hold = rx_new;
            next_s.rx_unread = 1'b1;
          end
        end
      end

      // transmit: byte boundary copies holding or underflows
      if (tx_fall && !start_ev)
      begin
        if (s.tx_cnt == 3'h0)
        begin
          if (s.tx_hold_full)
          begin
            tx_byte = s.tx_hold;
            next_s.tx_hold_full = 1'b0;
            next_s.tx_ready = 1'b1;
            ev[INT_TXC] = 1'b1;
          end
          else
          begin
            // rotation left the old byte intact, so it goes out again
            next_s.nonempty = 1'b0;
            // a same-cycle write keeps the flag up, so no event then
            ev[INT_UNDR] = s.nonempty & ~hold_wr;
          end
        end
        // open drain: drive low only for a zero bit
        next_s.sda_lvl = tx_byte[BYTE_W-1];
        next_s.sda_oe = ~tx_byte[BYTE_W-1];
        next_s.tx_sh = {tx_byte[BYTE_W-2:0], tx_byte[BYTE_W-1]};
        next_s.tx_cnt = s.tx_cnt + 3'h1;
      end

      // a write after the boundary logic so the set wins
      if (hold_wr)
      begin
        next_s.tx_hold = wr_data_in[BYTE_W-1:0];
        next_s.tx_hold_full = 1'b1;
        next_s.nonempty = 1'b1;
        next_s.tx_ready = 1'b0;
      end

      // never hold the line outside a frame or with transmit off
      if (!(s.ctl[CTL_TX_EN] && next_s.busy))
        next_s.sda_oe = 1'b0;
    end

    // sticky events: a new event beats a same-cycle clear
    next_s.int_st = (s.int_st & ~int_clr) | ev;
    next_s.irq = |(next_s.int_st & next_s.int_mask);

    // read data stand one cycle after the strobe only
    if (rd_in)
    begin
      case (addr_in)
        OFS_STATUS:
        begin
          next_s.rd_data[BIT_BUSY] = s.busy;
          next_s.rd_data[BIT_OVR] = s.overrun;
          next_s.rd_data[BIT_NONEMPTY] = s.nonempty;
          next_s.rd_data[BIT_TX_READY] = s.tx_ready;
          next_s.rd_data[BIT_RX_READY] = s.rx_unread;
        end
        OFS_RX_HOLD: next_s.rd_data[BYTE_W-1:0] = s.rx_hold;
        OFS_TX_HOLD: next_s.rd_data[BYTE_W-1:0] = s.tx_hold;
        OFS_CTRL: next_s.rd_data[CTL_W-1:0] = s.ctl;
        OFS_INT_ST: next_s.rd_data[INT_W-1:0] = s.int_st;
        OFS_INT_MASK: next_s.rd_data[INT_W-1:0] = s.int_mask;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s <= STATE_RST;
    else
      s <= next_s;
  end

  // outputs straight from the state flops
  assign rd_data_out = s.rd_data;
  assign sda_out = s.sda_lvl;
  assign sda_oe_out = s.sda_oe;
  assign busy_out = s.busy;
  assign irq_out = s.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence start_s;
    run && start_ev;
  endsequence

  sequence stop_s;
    run && stop_ev && !start_ev;
  endsequence

  sequence overrun_s;
    byte_done && s.rx_unread && !cpu_rd_hold && !start_ev;
  endsequence

  sequence underflow_s;
    bnd && !s.tx_hold_full && !hold_wr && !start_ev;
  endsequence

  bus_start_a: assert property (
    start_s |=> s.busy && busy_out ##1 1)
    else $error("busy flag not set after start");

  bus_stop_a: assert property (
    stop_s |=> !s.busy && !busy_out)
    else $error("busy flag not cleared after stop");

  mod_reset_a: assert property (
    !run |=> !s.busy && !s.overrun && s.nonempty)
    else $error("module reset left flags wrong");

  ovr_set_a: assert property (
    overrun_s |=> s.overrun && rd_in == 1'b0 || s.overrun)
    else $error("overrun not flagged on unread byte");

  ovr_hold_a: assert property (
    (run && s.overrun && !cpu_rd_hold)
      |=> $stable(s.rx_hold) && s.rx_unread)
    else $error("holding register replaced during overrun");

  ovr_clear_a: assert property (
    (cpu_rd_hold && !byte_done)
      |=> !s.overrun ##1 (!s.overrun || $past(byte_done)))
    else $error("processor read did not clear overrun");

  dbg_keep_a: assert property (
    (dbg_rd_hold && s.overrun) |=> s.overrun)
    else $error("debug read disturbed overrun");

  undr_set_a: assert property (
    underflow_s |=> !s.nonempty && s.tx_ready == $past(s.tx_ready))
    else $error("underflow not flagged");

  undr_resend_a: assert property (
    underflow_s |=> s.sda_lvl == $past(s.tx_sh[BYTE_W-1])
      && $stable(s.tx_hold))
    else $error("old byte not resent during underflow");

  hold_write_a: assert property (
    hold_wr |=> s.nonempty && !s.tx_ready && s.tx_hold_full)
    else $error("holding write did not set nonempty");

  copy_ready_a: assert property (
    (bnd && s.tx_hold_full && !hold_wr && !start_ev)
      |=> s.tx_ready && s.tx_sh == {$past(s.tx_hold[BYTE_W-2:0]),
        $past(s.tx_hold[BYTE_W-1])})
    else $error("copy did not set ready flag");

  stat_ro_a: assert property (
    (stat_wr && !start_ev && !stop_ev && !byte_done && !bnd
      && !cpu_rd_hold && !hold_wr && run)
      |=> $stable(s.busy) && $stable(s.overrun) && $stable(s.nonempty))
    else $error("status write changed a read-only flag");

  busy_read_a: assert property (
    (rd_in && addr_in == OFS_STATUS)
      |=> rd_data_out[BIT_BUSY] == $past(s.busy))
    else $error("busy flag not at its status bit");

endmodule : bflg_flags

`default_nettype wire

// file: hw/bflg_pkg.sv
// package: register map, field positions, reset values and types
package bflg_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_RX_HOLD = 8'h04;
  localparam logic [7:0] OFS_TX_HOLD = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_INT_ST = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;

  // ==========================================================
  // status field positions
  localparam int BIT_BUSY = 12;
  localparam int BIT_OVR = 11;
  localparam int BIT_NONEMPTY = 10;
  localparam int BIT_TX_READY = 4;
  localparam int BIT_RX_READY = 3;

  // control field positions
  localparam int CTL_RUN = 0;
  localparam int CTL_RX_EN = 1;
  localparam int CTL_TX_EN = 2;
  localparam int CTL_W = 3;

  // interrupt event positions
  localparam int INT_START = 0;
  localparam int INT_STOP = 1;
  localparam int INT_OVR = 2;
  localparam int INT_UNDR = 3;
  localparam int INT_RXB = 4;
  localparam int INT_TXC = 5;
  localparam int INT_W = 6;

  // widths and counts
  localparam int REG_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ==========================================================
  // reset values
  localparam logic [CTL_W-1:0] RST_CTRL = 3'h0;
  localparam logic [INT_W-1:0] RST_MASK = 6'h00;
  localparam logic RST_NONEMPTY = 1'b1;
  localparam logic RST_TX_READY = 1'b1;

  // ==========================================================
  // types
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
  } bflg_cond_t;

  typedef struct packed {
    logic [CTL_W-1:0] ctl;
    logic [INT_W-1:0] int_mask;
    logic [INT_W-1:0] int_st;
    logic busy;
    logic overrun;
    logic nonempty;
    logic tx_ready;
    logic rx_unread;
    logic tx_hold_full;
    logic [BYTE_W-1:0] rx_sh;
    logic [BYTE_W-1:0] rx_hold;
    logic [BYTE_W-1:0] tx_sh;
    logic [BYTE_W-1:0] tx_hold;
    logic [2:0] rx_cnt;
    logic [2:0] tx_cnt;
    logic [REG_W-1:0] rd_data;
    logic irq;
    logic sda_oe;
    logic sda_lvl;
  } bflg_state_t;

  localparam bflg_state_t STATE_RST = '{ctl: RST_CTRL, int_mask: RST_MASK,
    nonempty: RST_NONEMPTY, tx_ready: RST_TX_READY, default: '0};

endpackage : bflg_pkg

// file: hw/bflg_sync.sv
// two flip-flop synchroniser for the bus pins
`timescale 1ns/10ps
`default_nettype none

module bflg_sync
  import bflg_pkg::*;
#(
  parameter int W = 2
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // pins and synchronised copy
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  // ==========================================================
  // stage one is read only by stage two
  logic [2*W-1:0] st;
  logic [2*W-1:0] next_st;

  always_comb
  begin
    next_st = {st[W-1:0], d_in};
  end

  // reset to the idle high level of pulled-up pins, so the edge
  // detector behind sees no false edge once reset lets go
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st <= '1;
    else
      st <= next_st;
  end

  assign q_out = st[2*W-1:W];

endmodule : bflg_sync

`default_nettype wire

// file: hw/bflg_cond.sv
// start, stop and clock edge detector on synchronised pins
`timescale 1ns/10ps
`default_nettype none

module bflg_cond
  import bflg_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // synchronised pins
  input wire logic scl_in,
  input wire logic sda_in,
  // one-cycle condition pulses
  output bflg_cond_t cond_out
);

  // ==========================================================
  typedef struct packed {
    logic scl;
    logic sda;
    bflg_cond_t cond;
  } bflg_det_t;

  bflg_det_t st;
  bflg_det_t next_st;

  // data moving while the clock stays high marks start or stop
  always_comb
  begin
    next_st.scl = scl_in;
    next_st.sda = sda_in;
    next_st.cond.start = st.scl & scl_in & st.sda & ~sda_in;
    next_st.cond.stop = st.scl & scl_in & ~st.sda & sda_in;
    next_st.cond.scl_rise = ~st.scl & scl_in;
    next_st.cond.scl_fall = st.scl & ~scl_in;
  end

  // history resets to the idle high pins so no edge fires after reset
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st <= '{scl: 1'b1, sda: 1'b1, cond: '0};
    else
      st <= next_st;
  end

  assign cond_out = st.cond;

endmodule : bflg_cond

`default_nettype wire

// file: bench/bflg_bus_node.sv
// two-wire bus node model: start, stop, byte send and byte receive
`timescale 1ns/10ps
`default_nettype none

module bflg_bus_node
(
  // wired data line as seen by every node
  input wire logic sda_in,
  // own pin drive: clock driven both ways, data open drain
  output logic scl_out,
  output logic sda_low_out
);
  // ==========================================================
  // idle bus: clock stands high, data released to the pull-up
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // ==========================================================
  // framing; start and stop move data while the clock stands high
  task automatic start_cond();
    sda_low_out = 1'b1;
    #62.5;
  endtask : start_cond

  task automatic stop_cond();
    scl_out = 1'b0;
    sda_low_out = 1'b1;
    #62.5;
    scl_out = 1'b1;
    #31.25;
    sda_low_out = 1'b0;
    #62.5;
  endtask : stop_cond

  // msb first, 125 ns per bit
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      scl_out = 1'b0;
      #31.25;
      sda_low_out = ~b[i];
      #31.25;
      scl_out = 1'b1;
      #62.5;
    end
  endtask : send_byte

  // release after the fall so a release never reads as a stop
  task automatic recv_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      scl_out = 1'b0;
      #5;
      sda_low_out = 1'b0;
      #57.5;
      scl_out = 1'b1;
      #50;
      b[i] = sda_in;
      #12.5;
    end
  endtask : recv_byte
endmodule : bflg_bus_node
`default_nettype wire

// file: bench/test_i2c_busy_overrun_underflow_flags.sv
// self-checking bench for the status flag block
`timescale 1ns/10ps
`default_nettype none

module test_i2c_busy_overrun_underflow_flags
  import bflg_pkg::*;
;
  // ==========================================================
  // signals
  logic clk_in, rst_n_in, wr, rd, dbg, tx_s, tx_p;
  logic [7:0] addr, b;
  logic [REG_W-1:0] wdata, rdata, rv;
  logic sda_o, sda_oe, busy, irq, scl, node_low;
  wire logic sda_w;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;

  // wired-and data line with pull-up
  assign sda_w = ~(sda_oe & ~sda_o) & ~node_low;

  bflg_flags i_bflg_flags (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd),
    .dbg_rd_in(dbg), .rd_data_out(rdata), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .tx_start_evt_in(tx_s),
    .tx_stop_evt_in(tx_p), .busy_out(busy), .irq_out(irq));

  bflg_bus_node i_bflg_bus_node (.sda_in(sda_w), .scl_out(scl),
    .sda_low_out(node_low));

  // ==========================================================
  // clock and watchdog; the tests need about 2300 cycles
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      error_cnt++;
      results();
    end
  end

  // ==========================================================
  // compares and bus cycles
  task automatic chk16(input string n, input logic [15:0] e,
    input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk16

  task automatic chk1(input string n, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %b got %b", n, e, g);
    end
  endtask : chk1

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic d,
    output logic [15:0] v);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    dbg <= d;
    @(posedge clk_in);
    rd <= 1'b0;
    dbg <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg

  task automatic st();
    rd_reg(OFS_STATUS, 1'b0, rv);
  endtask : st

  // pin changes take four edges to reach the flags; look off the edge
  task automatic settle();
    repeat (6) @(posedge clk_in);
    #1;
  endtask : settle

  task automatic pulse(input logic stop);
    @(posedge clk_in);
    tx_s <= ~stop;
    tx_p <= stop;
    @(posedge clk_in);
    tx_s <= 1'b0;
    tx_p <= 1'b0;
    settle();
  endtask : pulse

  // ==========================================================
  // scenarios
  task automatic t_regs();
    st();
    chk16("status", 16'h0410, rv);
    wr_reg(OFS_STATUS, 16'hFFFF);
    st();
    chk16("status ro", 16'h0410, rv);
    rd_reg(8'h20, 1'b0, rv);
    chk16("unmapped", 16'h0000, rv);
    $display("test regs done");
  endtask : t_regs

  task automatic t_rx();
    wr_reg(OFS_CTRL, 16'h0003);
    wr_reg(OFS_INT_MASK, 16'h0001);
    pulse(1'b0);
    chk1("busy", 1'b1, busy);
    pulse(1'b1);
    chk1("busy", 1'b0, busy);
    wr_reg(OFS_INT_ST, 16'h003F);
    i_bflg_bus_node.start_cond();
    settle();
    st();
    chk1("busy bit", 1'b1, rv[BIT_BUSY]);
    chk1("irq", 1'b1, irq);
    wr_reg(OFS_INT_ST, 16'h0001);
    settle();
    chk1("irq clr", 1'b0, irq);
    i_bflg_bus_node.send_byte(8'h5A);
    i_bflg_bus_node.send_byte(8'hC3);
    i_bflg_bus_node.send_byte(8'h96);
    settle();
    st();
    chk1("overrun", 1'b1, rv[BIT_OVR]);
    rd_reg(OFS_RX_HOLD, 1'b1, rv);
    chk16("dbg rx", 16'h005A, rv);
    st();
    chk1("overrun", 1'b1, rv[BIT_OVR]);
    rd_reg(OFS_RX_HOLD, 1'b0, rv);
    chk16("rx", 16'h005A, rv);
    st();
    chk1("overrun", 1'b0, rv[BIT_OVR]);
    rd_reg(OFS_RX_HOLD, 1'b0, rv);
    chk16("rx late", 16'h0096, rv);
    i_bflg_bus_node.stop_cond();
    settle();
    chk1("busy", 1'b0, busy);
    st();
    chk1("busy bit", 1'b0, rv[BIT_BUSY]);
    $display("test rx done");
  endtask : t_rx

  task automatic t_rst();
    i_bflg_bus_node.start_cond();
    i_bflg_bus_node.send_byte(8'h11);
    i_bflg_bus_node.send_byte(8'h22);
    settle();
    wr_reg(OFS_CTRL, 16'h0000);
    st();
    chk16("status", 16'h0410, rv);
    i_bflg_bus_node.stop_cond();
    $display("test module reset done");
  endtask : t_rst

  task automatic t_tx();
    wr_reg(OFS_CTRL, 16'h0005);
    wr_reg(OFS_TX_HOLD, 16'h00A5);
    st();
    chk1("nonempty", 1'b1, rv[BIT_NONEMPTY]);
    chk1("tx ready", 1'b0, rv[BIT_TX_READY]);
    i_bflg_bus_node.start_cond();
    i_bflg_bus_node.recv_byte(b);
    chk16("tx", 16'h00A5, {8'h00, b});
    st();
    chk1("tx ready", 1'b1, rv[BIT_TX_READY]);
    i_bflg_bus_node.recv_byte(b);
    chk16("resend", 16'h00A5, {8'h00, b});
    st();
    chk1("nonempty", 1'b0, rv[BIT_NONEMPTY]);
    rd_reg(OFS_INT_ST, 1'b0, rv);
    chk1("underflow int", 1'b1, rv[INT_UNDR]);
    wr_reg(OFS_TX_HOLD, 16'h00BC);
    st();
    chk1("nonempty", 1'b1, rv[BIT_NONEMPTY]);
    i_bflg_bus_node.recv_byte(b);
    chk16("tx new", 16'h00BC, {8'h00, b});
    i_bflg_bus_node.stop_cond();
    $display("test tx done");
  endtask : t_tx

  // ==========================================================
  // verdict
  task automatic results();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  initial
  begin
    rst_n_in = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    dbg = 1'b0;
    tx_s = 1'b0;
    tx_p = 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_rx();
    t_rst();
    t_tx();
    results();
  end
endmodule : test_i2c_busy_overrun_underflow_flags
`default_nettype wire
